// ===== cmd_pkg.sv
package cmd_pkg;
    localparam int CMD_DW = 16;
    localparam int CMD_RW = 32;
    localparam int CMD_MODE_W = 7;
    // Instruction kinds on the link
    localparam logic [1:0] CMD_INSTR_MODE = 2'h0;
    localparam logic [1:0] CMD_INSTR_PRELOAD = 2'h1;
    localparam logic [1:0] CMD_INSTR_SEND = 2'h2;
    // Mode fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_MSB = 3;
    localparam int CMD_OUT_LSB = 4;
    localparam int CMD_OUT_MSB = 6;
    localparam logic [3:0] CMD_OP_CLEAR = 4'h0;
    localparam logic [3:0] CMD_OP_LOAD16 = 4'h1;
    localparam logic [3:0] CMD_OP_LOAD32 = 4'h2;
    localparam logic [3:0] CMD_OP_READ = 4'h3;
    localparam logic [3:0] CMD_OP_MULU = 4'h4;
    localparam logic [3:0] CMD_OP_MULS = 4'h5;
    localparam logic [3:0] CMD_OP_DIVU = 4'h8;
    localparam logic [3:0] CMD_OP_DIVS = 4'h9;
    localparam logic [3:0] CMD_OP_LOAD1 = 4'hA;
    localparam logic [2:0] CMD_OUT_R0_LO = 3'h0;
    localparam logic [2:0] CMD_OUT_R0_HI = 3'h1;
    localparam logic [2:0] CMD_OUT_R1_LO = 3'h2;
    localparam logic [2:0] CMD_OUT_R1_HI = 3'h3;
    localparam logic [6:0] CMD_MODE_RESET = 7'h00;
    localparam logic [3:0] CMD_FLAGS_CLEAR = 4'h0;
    localparam int CMD_DIV_STEPS = 32;
    typedef enum logic [1:0] {
        CMD_ST_IDLE = 2'b01,
        CMD_ST_DIV = 2'b10
    } cmd_state_e;
endpackage

// ===== cmd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cmd_link_if;
    import cmd_pkg::*;
    logic req;
    logic [1:0] instr;
    logic [CMD_DW-1:0] opa;
    logic [CMD_DW-1:0] opb;
    logic busy;
    logic rsp_valid;
    logic [CMD_DW-1:0] rsp_data;
    logic [3:0] condition_flags;
    modport dev (input req, input instr, input opa, input opb,
                 output busy, output rsp_valid, output rsp_data, output condition_flags);
    modport cpu (output req, output instr, output opa, output opb,
                 input busy, input rsp_valid, input rsp_data, input condition_flags);
endinterface
`default_nettype wire

// ===== cmd_coproc.sv
// Overview of operation
// - Modes 0x04/0x05 select unsigned/signed multiply
// - Multiply stores 32-bit product in result_reg_zero
// - Output field 1 returns product high half
// - Multiply clears flags; product held
// - Mode 0x13 returns result_reg_zero high half
// - Preload in mode 0x02 forms 32-bit dividend
// - Modes 0x08/0x09 select unsigned/signed divide
// - Divide puts quotient r0, remainder r1
// - Output field picks quotient/remainder half
// - Modes 0x23/0x33 read remainder halves
// - Extension immediate arrives as low operand
// - Divide clears flags; results held
// - CPU never requests zero by zero
// - Mode bits 3:0 operation, 6:4 output
// - Operation 0x3 reads without computing
`timescale 1ns/1ps
`default_nettype none
module cmd_coproc (
    input wire logic clk,
    input wire logic srst,
    cmd_link_if.dev link
);
    import cmd_pkg::*;

    logic [CMD_MODE_W-1:0] mode_reg;
    logic [CMD_RW-1:0] result_reg_zero_reg, result_reg_zero_next;
    logic [CMD_RW-1:0] result_reg_one_reg, result_reg_one_next;
    logic [CMD_DW-1:0] rsp_data_reg;
    logic rsp_valid_reg, busy_reg;
    logic [3:0] flags_reg;
    cmd_state_e state_reg;
    logic [5:0] step_reg;
    logic [CMD_RW-1:0] quo_reg, rem_reg, dvs_reg;
    logic neg_q_reg, neg_r_reg;

    ////////////////////////////////////////////////////////////////
    // Decode
    wire [3:0] op = mode_reg[CMD_OP_MSB:CMD_OP_LSB];
    wire [2:0] outsel = mode_reg[CMD_OUT_MSB:CMD_OUT_LSB];
    wire idle = (state_reg == CMD_ST_IDLE);
    wire take = link.req && idle;
    wire is_mode = take && (link.instr == CMD_INSTR_MODE);
    wire is_pre = take && (link.instr == CMD_INSTR_PRELOAD);
    wire is_send = take && (link.instr == CMD_INSTR_SEND);
    wire [CMD_RW-1:0] pair = {link.opa, link.opb};
    wire is_mul = (op == CMD_OP_MULU) || (op == CMD_OP_MULS);
    wire is_div = (op == CMD_OP_DIVU) || (op == CMD_OP_DIVS);
    wire sgn = op[0];
    // Multiplier, one cycle
    wire signed [CMD_DW:0] ma = {sgn & link.opa[CMD_DW-1], link.opa};
    wire signed [CMD_DW:0] mb = {sgn & link.opb[CMD_DW-1], link.opb};
    wire signed [2*CMD_DW+1:0] mfull = ma * mb;
    wire [CMD_RW-1:0] prod = mfull[CMD_RW-1:0];
    // Divider operand magnitudes
    wire dvd_neg = (op == CMD_OP_DIVS) && result_reg_zero_reg[CMD_RW-1];
    wire dvs_neg = (op == CMD_OP_DIVS) && link.opa[CMD_DW-1];
    wire [CMD_RW-1:0] dvd_abs = dvd_neg ? CMD_RW'(-result_reg_zero_reg) : result_reg_zero_reg;
    wire [CMD_RW-1:0] dvs_abs = dvs_neg ? CMD_RW'(-pair) : pair;
    // Restoring step
    wire [CMD_RW:0] trial = {rem_reg, quo_reg[CMD_RW-1]} - {1'b0, dvs_reg};
    wire fits = !trial[CMD_RW];
    wire [CMD_RW-1:0] rem_step = fits ? trial[CMD_RW-1:0]
                                      : {rem_reg[CMD_RW-2:0], quo_reg[CMD_RW-1]};
    wire [CMD_RW-1:0] quo_step = {quo_reg[CMD_RW-2:0], fits};
    wire last = (step_reg == 6'(CMD_DIV_STEPS - 1));
    wire [CMD_RW-1:0] q_fin = neg_q_reg ? CMD_RW'(-quo_step) : quo_step;
    wire [CMD_RW-1:0] r_fin = neg_r_reg ? CMD_RW'(-rem_step) : rem_step;

    ////////////////////////////////////////////////////////////////
    // Result registers
    always_comb begin
        result_reg_zero_next = result_reg_zero_reg;
        result_reg_one_next = result_reg_one_reg;
        if (is_mode && link.opb[3:0] == CMD_OP_CLEAR) begin
            result_reg_zero_next = '0;
            result_reg_one_next = '0;
        end else if (is_pre && op == CMD_OP_LOAD16) begin
            result_reg_zero_next = {{CMD_DW{1'b0}}, link.opb};
        end else if (is_pre && op == CMD_OP_LOAD32) begin
            result_reg_zero_next = pair;
        end else if (is_pre && op == CMD_OP_LOAD1) begin
            result_reg_one_next = pair;
        end else if (is_send && is_mul) begin
            result_reg_zero_next = prod;
        end else if (state_reg == CMD_ST_DIV && last) begin
            result_reg_zero_next = q_fin;
            result_reg_one_next = r_fin;
        end
    end

    // Half selection from next result state
    function automatic logic [CMD_DW-1:0] pick(input logic [2:0] s,
            input logic [CMD_RW-1:0] r0, input logic [CMD_RW-1:0] r1);
        case (s)
            CMD_OUT_R0_HI: pick = r0[CMD_RW-1:CMD_DW];
            CMD_OUT_R1_LO: pick = r1[CMD_DW-1:0];
            CMD_OUT_R1_HI: pick = r1[CMD_RW-1:CMD_DW];
            default: pick = r0[CMD_DW-1:0];
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_reg <= CMD_MODE_RESET;
            result_reg_zero_reg <= '0;
            result_reg_one_reg <= '0;
        end else begin
            if (is_mode)
                mode_reg <= link.opb[CMD_MODE_W-1:0];
            result_reg_zero_reg <= result_reg_zero_next;
            result_reg_one_reg <= result_reg_one_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Divider sequencer and answer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= CMD_ST_IDLE;
            step_reg <= '0;
            quo_reg <= '0;
            rem_reg <= '0;
            dvs_reg <= '0;
            neg_q_reg <= 1'b0;
            neg_r_reg <= 1'b0;
            busy_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= '0;
            flags_reg <= CMD_FLAGS_CLEAR;
        end else begin
            rsp_valid_reg <= 1'b0;
            case (state_reg)
                CMD_ST_IDLE: begin
                    if (is_send && is_div) begin
                        state_reg <= CMD_ST_DIV;
                        busy_reg <= 1'b1;
                        step_reg <= '0;
                        quo_reg <= dvd_abs;
                        rem_reg <= '0;
                        dvs_reg <= dvs_abs;
                        neg_q_reg <= dvd_neg ^ dvs_neg;
                        neg_r_reg <= dvd_neg;
                    end else if (is_send) begin
                        // Multiply, read or other: answer next cycle
                        rsp_valid_reg <= 1'b1;
                        rsp_data_reg <= pick(outsel, result_reg_zero_next, result_reg_one_next);
                        flags_reg <= CMD_FLAGS_CLEAR;
                    end
                end
                CMD_ST_DIV: begin
                    quo_reg <= quo_step;
                    rem_reg <= rem_step;
                    step_reg <= step_reg + 6'h01;
                    if (last) begin
                        state_reg <= CMD_ST_IDLE;
                        busy_reg <= 1'b0;
                        rsp_valid_reg <= 1'b1;
                        rsp_data_reg <= pick(outsel, result_reg_zero_next, result_reg_one_next);
                        flags_reg <= CMD_FLAGS_CLEAR;
                    end
                end
                default: state_reg <= CMD_ST_IDLE;
            endcase
        end
    end

    assign link.busy = busy_reg;
    assign link.rsp_valid = rsp_valid_reg;
    assign link.rsp_data = rsp_data_reg;
    assign link.condition_flags = flags_reg;
endmodule
`default_nettype wire

// ===== cmd_cpu_end.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_cpu_end (
    input wire logic clk,
    input wire logic srst,
    input wire logic user_valid,
    input wire logic [1:0] user_instr,
    input wire logic [15:0] user_opa,
    input wire logic [15:0] user_opb,
    output logic user_ready,
    output logic user_done,
    output logic [15:0] user_data,
    output logic [3:0] user_flags,
    cmd_link_if.cpu link
);
    import cmd_pkg::*;

    logic req_reg, wait_reg, done_reg;
    logic [1:0] instr_reg;
    logic [CMD_DW-1:0] opa_reg, opb_reg, data_reg;
    logic [3:0] flags_reg;

    // One instruction outstanding; a send waits for its answer
    wire sent = req_reg && !link.busy;
    wire accept = !req_reg && !wait_reg && !done_reg && user_valid;

    always_ff @(posedge clk) begin
        if (srst) begin
            req_reg <= 1'b0;
            wait_reg <= 1'b0;
            done_reg <= 1'b0;
            instr_reg <= CMD_INSTR_MODE;
            opa_reg <= '0;
            opb_reg <= '0;
            data_reg <= '0;
            flags_reg <= CMD_FLAGS_CLEAR;
        end else begin
            done_reg <= 1'b0;
            if (accept) begin
                // Instruction and both operands latched together
                req_reg <= 1'b1;
                instr_reg <= user_instr;
                opa_reg <= user_opa;
                opb_reg <= user_opb;
            end else if (sent) begin
                req_reg <= 1'b0;
                wait_reg <= (instr_reg == CMD_INSTR_SEND);
                done_reg <= (instr_reg != CMD_INSTR_SEND);
            end else if (wait_reg && link.rsp_valid) begin
                wait_reg <= 1'b0;
                done_reg <= 1'b1;
                data_reg <= link.rsp_data;
                flags_reg <= link.condition_flags;
            end
        end
    end

    assign link.req = req_reg;
    assign link.instr = instr_reg;
    assign link.opa = opa_reg;
    assign link.opb = opb_reg;
    assign user_ready = !req_reg && !wait_reg && !done_reg;
    assign user_done = done_reg;
    assign user_data = data_reg;
    assign user_flags = flags_reg;
endmodule
`default_nettype wire

// ===== cmd_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_link_asserts
    import cmd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic req,
    input wire logic [1:0] instr,
    input wire logic [CMD_DW-1:0] opa,
    input wire logic [CMD_DW-1:0] opb,
    input wire logic busy,
    input wire logic rsp_valid,
    input wire logic [CMD_DW-1:0] rsp_data,
    input wire logic [3:0] condition_flags
);
    logic [6:0] mode_reg;
    wire logic take = req && !busy;
    wire logic send = take && (instr == CMD_INSTR_SEND);
    wire logic is_div = (mode_reg[3:0] == CMD_OP_DIVU) || (mode_reg[3:0] == CMD_OP_DIVS);
    wire logic is_mul = (mode_reg[3:1] == 3'h2) && (mode_reg[6:5] == 2'h0);
    wire logic [31:0] pu = opa * opb;
    wire logic [31:0] ps = $signed(opa) * $signed(opb);
    wire logic [31:0] prod = mode_reg[0] ? ps : pu;
    wire logic [15:0] mul_half = mode_reg[4] ? prod[31:16] : prod[15:0];
    // Shadow of the mode last taken
    always_ff @(posedge clk) begin
        if (srst) begin
            mode_reg <= CMD_MODE_RESET;
        end else if (take && instr == CMD_INSTR_MODE) begin
            mode_reg <= opb[6:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    a_flags_zero: assert property (condition_flags == CMD_FLAGS_CLEAR)
        else $error("condition flags not zero");
    a_mul_half: assert property (send && is_mul |=> rsp_valid && rsp_data == $past(mul_half))
        else $error("wrong product half");
    a_quick_answer: assert property (send && !is_div |=> rsp_valid && !busy)
        else $error("single cycle answer missing");
    a_div_busy: assert property (send && is_div |=> busy [*8])
        else $error("divide not stalling");
    a_div_answer: assert property (send && is_div |-> ##33 (rsp_valid && !busy))
        else $error("divide answer late");
    a_busy_quiet: assert property (busy |-> !rsp_valid)
        else $error("answer while busy");
    a_setup_quiet: assert property (take && instr != CMD_INSTR_SEND |=> !rsp_valid)
        else $error("answer to setup");
    a_data_hold: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("answer data moved");
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cmd_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic uv = 1'b0;
    logic [1:0] ui = 2'h0;
    logic [15:0] ua = 16'h0000;
    logic [15:0] ub = 16'h0000;
    logic ur, ud;
    logic [15:0] udat, d;
    logic [3:0] uf;
    logic [31:0] p;
    int n_fail = 0;
    int n_checks = 0;
    logic [6:0] mm [4] = '{7'h04, 7'h14, 7'h05, 7'h15};
    logic [15:0] ma [4] = '{16'hFFFF, 16'h1234, 16'hFFFE, 16'h8000};
    logic [15:0] mb [4] = '{16'hFFFF, 16'h5678, 16'h0003, 16'h7FFF};
    logic [31:0] dvv [2] = '{32'hFFFFFFFF, 32'h80000001};
    logic [31:0] dsv [2] = '{32'h00012345, 32'hFFFFFFF9};
    logic [31:0] qv [2] = '{32'h0000E100, 32'h12492492};
    logic [31:0] rv [2] = '{32'h00005AFF, 32'hFFFFFFFF};
    cmd_link_if link();
    always #10 clk = ~clk;
    cmd_coproc u_cmd_coproc (.clk(clk), .srst(srst), .link(link));
    cmd_cpu_end u_cmd_cpu_end (.clk(clk), .srst(srst), .user_valid(uv), .user_instr(ui),
        .user_opa(ua), .user_opb(ub), .user_ready(ur), .user_done(ud), .user_data(udat),
        .user_flags(uf), .link(link));
    cmd_link_asserts u_chk (.clk(clk), .srst(srst), .req(link.req), .instr(link.instr),
        .opa(link.opa), .opb(link.opb), .busy(link.busy), .rsp_valid(link.rsp_valid),
        .rsp_data(link.rsp_data), .condition_flags(link.condition_flags));
    ////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic issue(input logic [1:0] k, input logic [15:0] x, input logic [15:0] y);
        int n;
        @(negedge clk);
        for (n = 0; ur !== 1'b1; n++) begin
            if (n == 100) begin
                n_fail++;
                results();
            end
            @(negedge clk);
        end
        // Valid only for the one edge that takes it
        uv = 1'b1;
        ui = k;
        ua = x;
        ub = y;
        @(negedge clk);
        uv = 1'b0;
    endtask
    task automatic send(input logic [15:0] x, input logic [15:0] y);
        int n;
        issue(CMD_INSTR_SEND, x, y);
        for (n = 0; ud !== 1'b1; n++) begin
            if (n == 100) begin
                n_fail++;
                results();
            end
            @(negedge clk);
        end
        d = udat;
        chk("flags", {12'h000, uf}, 16'h0000);
    endtask
    task automatic md(input logic [6:0] m);
        issue(CMD_INSTR_MODE, 16'h0000, {9'h000, m});
    endtask
    function automatic logic [15:0] half(input logic [31:0] q, input logic [31:0] r, input int o);
        logic [63:0] w;
        w = {r, q};
        return w[o*16 +: 16];
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        for (int j = 0; j < 4; j++) begin
            if (mm[j][0]) begin
                p = $signed(ma[j]) * $signed(mb[j]);
            end else begin
                p = ma[j] * mb[j];
            end
            md(mm[j]);
            send(ma[j], mb[j]);
            chk("mul", d, mm[j][4] ? p[31:16] : p[15:0]);
            md(7'h13);
            send(16'h0000, 16'h0000);
            chk("mul_high", d, p[31:16]);
        end
        $display("mul test done");
        for (int s = 0; s < 2; s++) begin
            for (int o = 0; o < 4; o++) begin
                md(7'h02);
                issue(CMD_INSTR_PRELOAD, dvv[s][31:16], dvv[s][15:0]);
                md({o[2:0], 3'h4, s[0]});
                send(dsv[s][31:16], dsv[s][15:0]);
                chk("div", d, half(qv[s], rv[s], o));
                for (int k = 0; k < 4; k++) begin
                    md({k[2:0], 4'h3});
                    send(16'h0000, 16'h0000);
                    chk("div_read", d, half(qv[s], rv[s], k));
                end
            end
        end
        $display("div test done");
        md(7'h01);
        issue(CMD_INSTR_PRELOAD, 16'h5555, 16'hABCD);
        md(7'h0A);
        issue(CMD_INSTR_PRELOAD, 16'h1357, 16'h2468);
        for (int k = 0; k < 4; k++) begin
            md({k[2:0], 4'h3});
            send(16'h0000, 16'h0000);
            chk("preload", d, half(32'h0000ABCD, 32'h13572468, k));
        end
        $display("preload test done");
        md(7'h00);
        md(7'h23);
        send(16'h1111, 16'h2222);
        chk("clear", d, 16'h0000);
        $display("clear test done");
        results();
    end
endmodule
`default_nettype wire
